// file: hw/vectored_irq_defs.vh
// Constants for the vectored interrupt and stop-wake block.
// Assumes byte-wide registers on a plain strobe port.
`ifndef VECTORED_IRQ_DEFS_VH
`define VECTORED_IRQ_DEFS_VH

// Register addresses
`define REQ_REG_ADDR 8'hFA
`define PRIO_REG_ADDR 8'hF9
`define MASK_REG_ADDR 8'hFB
`define WAKE_REG_ADDR 8'h0B

// Request register fields
`define REQ_TWO_EDGE_BIT 7
`define REQ_ZERO_EDGE_BIT 6
`define REQ_SRC_COUNT 6
`define REQ_RESET 8'h00

// Mask register fields
`define MASK_MASTER_BIT 7
`define MASK_RESET 8'h00

// Priority register fields
`define PRIO_RESET 8'h00

// Stop-wake register fields
`define WAKE_WARM_BIT 7
`define WAKE_LEVEL_BIT 6
`define WAKE_DELAY_BIT 5
`define WAKE_SEL_HI 4
`define WAKE_SEL_LO 2
`define WAKE_RESET 8'h20

// Wake source codes
`define WAKE_SRC_RESET_ONLY 3'h0
`define WAKE_SRC_RESERVED 3'h1
`define WAKE_SRC_PIN31 3'h2
`define WAKE_SRC_PIN32 3'h3
`define WAKE_SRC_PIN33 3'h4
`define WAKE_SRC_PIN27 3'h5
`define WAKE_SRC_NOR_LOW4 3'h6
`define WAKE_SRC_NOR_ALL8 3'h7

// Default level forced on port 2 bits that are outputs
`define PORT2_OUT_DEFAULT 8'h00

// Vector table base in program memory
`define VECTOR_BASE 16'h0000

`endif

// file: hw/edge_sense.v
// Edge detector for one synchronous pin.
// Assumes the pin level is already synchronous to clk_i.
`timescale 1ns/1ps
module edge_sense (
  input wire clk_i,
  input wire reset_i,
  input wire level_i,
  input wire rise_en_i,
  input wire fall_en_i,
  output wire pulse_o
);

  reg prev_r;

  // Previous sample of the pin
  always @(posedge clk_i) begin
    if (reset_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_i;
    end
  end

  // One pulse per qualifying edge
  assign pulse_o = (rise_en_i & level_i & ~prev_r) |
                   (fall_en_i & ~level_i & prev_r);

endmodule

// file: hw/vectored_irq_and_stop_wake.v
// Vectored interrupt controller with stop-mode wake logic.
// Assumes synchronous pins, a core that grants at instruction
// boundaries and program memory that answers one cycle after a read.
//
// Behaviour
// - Among pending enabled requests a priority encoder set by the priority register picks one.
// - A grant runs an interrupt cycle that disables interrupts, saves PC and flags, then vectors.
// - Each vector is two consecutive bytes, high then low, loaded as a 16-bit PC.
// - Six two-byte vectors sit at the bottom of program memory, one per source.
// - Masked requests are still recorded in the request register for polling.
// - Comparator input a feeds request two and comparator input b feeds request zero.
// - Request register bits 7 and 6 select the trigger edges of requests two and zero.
// - Wake select bits 4 to 2 choose reset only or one of four single pins; 001 is reserved.
// - Wake codes 110 and 111 wake on the NOR of port 2 bits 0-3 or 0-7.
// - Port 2 bits configured as outputs feed the default level into the NOR.
// - Wake bit 5 enables the stabilisation delay after wake, resetting to 1.
// - Wake bit 6 selects high or low level wake and resets to 0.
// - Wake bit 7 is read-only, 1 after stop recovery and 0 after other resets.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "vectored_irq_defs.vh"
module vectored_irq_and_stop_wake (
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output reg [7:0] reg_rdata_o,
  input wire port3_pin1_i,
  input wire port3_pin2_i,
  input wire port3_pin3_i,
  input wire [7:0] port2_i,
  input wire [7:0] port2_out_mode_i,
  input wire comparator_input_a_i,
  input wire comparator_input_b_i,
  input wire timer_input_evt_i,
  input wire timer16_evt_i,
  input wire timer8_evt_i,
  input wire low_voltage_detector_evt_i,
  input wire core_boundary_i,
  output wire intr_cycle_o,
  output wire save_ctx_o,
  output wire prog_rd_o,
  output reg [15:0] prog_addr_o,
  input wire [7:0] prog_data_i,
  output wire pc_load_o,
  output reg [15:0] pc_value_o,
  input wire stop_mode_i,
  output reg wake_o,
  output reg wake_delay_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SAVE = 3'h1;
  localparam [2:0] ST_VHI = 3'h2;
  localparam [2:0] ST_VLO = 3'h3;
  localparam [2:0] ST_LOAD = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;

  reg [7:0] req_r;
  reg [7:0] req_nxt;
  reg [7:0] mask_r;
  reg [7:0] mask_nxt;
  reg [7:0] prio_r;
  reg [7:0] wake_r;
  reg [7:0] wake_nxt;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] src_r;
  reg [2:0] src_nxt;
  reg [15:0] addr_nxt;
  reg [15:0] pc_nxt;
  reg [7:0] rdata_nxt;
  reg wake_src;
  reg wake_hit;

  wire [5:0] set_evt;
  wire [5:0] pend;
  wire [3:0] pick_res;
  wire grant;
  wire two_rise;
  wire two_fall;
  wire zero_rise;
  wire zero_fall;
  wire evt_p31;
  wire evt_p32;
  wire evt_p33;
  wire evt_cmp_a;
  wire evt_cmp_b;
  wire [7:0] port2_eff;
  wire [2:0] wake_sel;

  // Rotating priority: first pending source from the start index
  function [3:0] pick;
    input [5:0] pending;
    input [2:0] start;
    integer i;
    integer k;
    reg found;
    reg [2:0] idx;
    begin
      found = 1'b0;
      idx = 3'h0;
      for (i = 0; i < `REQ_SRC_COUNT; i = i + 1) begin
        k = ((start % `REQ_SRC_COUNT) + i) % `REQ_SRC_COUNT;
        if (!found && pending[k]) begin
          found = 1'b1;
          idx = k[2:0];
        end
      end
      pick = {found, idx};
    end
  endfunction

  // Edge selection from request register bits 7 and 6
  assign two_rise = req_r[`REQ_TWO_EDGE_BIT];
  assign two_fall = ~req_r[`REQ_TWO_EDGE_BIT] |
                    req_r[`REQ_ZERO_EDGE_BIT];
  assign zero_rise = req_r[`REQ_ZERO_EDGE_BIT];
  assign zero_fall = ~req_r[`REQ_ZERO_EDGE_BIT] |
                     req_r[`REQ_TWO_EDGE_BIT];

  // Pin and comparator edge detectors
  edge_sense u_p31 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(port3_pin1_i),
    .rise_en_i(two_rise),
    .fall_en_i(two_fall),
    .pulse_o(evt_p31)
  );

  edge_sense u_p32 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(port3_pin2_i),
    .rise_en_i(zero_rise),
    .fall_en_i(zero_fall),
    .pulse_o(evt_p32)
  );

  edge_sense u_p33 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(port3_pin3_i),
    .rise_en_i(1'b0),
    .fall_en_i(1'b1),
    .pulse_o(evt_p33)
  );

  edge_sense u_cmp_a (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(comparator_input_a_i),
    .rise_en_i(two_rise),
    .fall_en_i(two_fall),
    .pulse_o(evt_cmp_a)
  );

  edge_sense u_cmp_b (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(comparator_input_b_i),
    .rise_en_i(zero_rise),
    .fall_en_i(zero_fall),
    .pulse_o(evt_cmp_b)
  );

  // Event sources mapped onto the six request bits
  assign set_evt[0] = evt_p32 | evt_cmp_b;
  assign set_evt[1] = evt_p33;
  assign set_evt[2] = evt_p31 | evt_cmp_a | timer_input_evt_i;
  assign set_evt[3] = timer16_evt_i;
  assign set_evt[4] = timer8_evt_i;
  assign set_evt[5] = low_voltage_detector_evt_i;

  // Enabled pending requests and the priority pick
  assign pend = req_r[5:0] & mask_r[5:0];
  assign pick_res = pick(pend, prio_r[2:0]);
  assign grant = (state_r == ST_IDLE) & core_boundary_i &
                 mask_r[`MASK_MASTER_BIT] & pick_res[3];

  // Strobes to the core sequencer
  assign intr_cycle_o = (state_r != ST_IDLE);
  assign save_ctx_o = (state_r == ST_SAVE);
  assign prog_rd_o = (state_r == ST_VHI) | (state_r == ST_VLO);
  assign pc_load_o = (state_r == ST_DONE);

  // Request register: software write, hardware set wins
  always @* begin
    req_nxt = req_r;
    if (reg_we_i && reg_addr_i == `REQ_REG_ADDR) begin
      req_nxt = reg_wdata_i;
    end
    if (grant) begin
      req_nxt[pick_res[2:0]] = 1'b0;
    end
    req_nxt[5:0] = req_nxt[5:0] | set_evt;
    req_nxt[7:6] = req_nxt[7:6];
  end

  // Mask register: grant drops the master enable
  always @* begin
    mask_nxt = mask_r;
    if (reg_we_i && reg_addr_i == `MASK_REG_ADDR) begin
      mask_nxt = reg_wdata_i;
    end
    if (grant) begin
      mask_nxt[`MASK_MASTER_BIT] = 1'b0;
    end
  end

  // Interrupt cycle sequencer
  always @* begin
    state_nxt = state_r;
    src_nxt = src_r;
    addr_nxt = prog_addr_o;
    pc_nxt = pc_value_o;
    case (state_r)
      ST_IDLE: begin
        if (grant) begin
          src_nxt = pick_res[2:0];
          state_nxt = ST_SAVE;
        end
      end
      ST_SAVE: begin
        addr_nxt = `VECTOR_BASE + {12'h000, src_r, 1'b0};
        state_nxt = ST_VHI;
      end
      ST_VHI: begin
        addr_nxt = prog_addr_o + 16'h0001;
        state_nxt = ST_VLO;
      end
      ST_VLO: begin
        pc_nxt[15:8] = prog_data_i;
        state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        pc_nxt[7:0] = prog_data_i;
        state_nxt = ST_DONE;
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Port 2 with output bits forced to the default level
  assign port2_eff = (port2_i & ~port2_out_mode_i) |
                     (`PORT2_OUT_DEFAULT & port2_out_mode_i);
  assign wake_sel = wake_r[`WAKE_SEL_HI:`WAKE_SEL_LO];

  // Wake source selection and level match
  always @* begin
    wake_src = 1'b0;
    wake_hit = 1'b0;
    case (wake_sel)
      `WAKE_SRC_PIN31: wake_src = port3_pin1_i;
      `WAKE_SRC_PIN32: wake_src = port3_pin2_i;
      `WAKE_SRC_PIN33: wake_src = port3_pin3_i;
      `WAKE_SRC_PIN27: wake_src = port2_i[7];
      `WAKE_SRC_NOR_LOW4: wake_src = ~|port2_eff[3:0];
      `WAKE_SRC_NOR_ALL8: wake_src = ~|port2_eff;
      default: wake_src = 1'b0;
    endcase
    // Reset-only and reserved codes never wake
    if (wake_sel != `WAKE_SRC_RESET_ONLY &&
        wake_sel != `WAKE_SRC_RESERVED) begin
      wake_hit = (wake_src == wake_r[`WAKE_LEVEL_BIT]);
    end
  end

  // Stop-wake register: warm flag set by recovery only
  always @* begin
    wake_nxt = wake_r;
    if (reg_we_i && reg_addr_i == `WAKE_REG_ADDR) begin
      wake_nxt[6:0] = reg_wdata_i[6:0];
    end
    if (stop_mode_i && wake_hit) begin
      wake_nxt[`WAKE_WARM_BIT] = 1'b1;
    end
  end

  // Read mux, zero for unmapped addresses
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      `REQ_REG_ADDR: rdata_nxt = req_r;
      `PRIO_REG_ADDR: rdata_nxt = prio_r;
      `MASK_REG_ADDR: rdata_nxt = mask_r;
      `WAKE_REG_ADDR: rdata_nxt = wake_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Register file and sequencer state
  always @(posedge clk_i) begin
    if (reset_i) begin
      req_r <= `REQ_RESET;
      mask_r <= `MASK_RESET;
      prio_r <= `PRIO_RESET;
      wake_r <= `WAKE_RESET;
      state_r <= ST_IDLE;
      src_r <= 3'h0;
      prog_addr_o <= 16'h0000;
      pc_value_o <= 16'h0000;
      reg_rdata_o <= 8'h00;
    end else begin
      req_r <= req_nxt;
      mask_r <= mask_nxt;
      if (reg_we_i && reg_addr_i == `PRIO_REG_ADDR) begin
        prio_r <= reg_wdata_i;
      end
      wake_r <= wake_nxt;
      state_r <= state_nxt;
      src_r <= src_nxt;
      prog_addr_o <= addr_nxt;
      pc_value_o <= pc_nxt;
      reg_rdata_o <= reg_re_i ? rdata_nxt : 8'h00;
    end
  end

  // Wake pulse with the delay choice captured beside it
  always @(posedge clk_i) begin
    if (reset_i) begin
      wake_o <= 1'b0;
      wake_delay_o <= 1'b1;
    end else begin
      // Sampled once per clock; fast wake relies on a held source
      wake_o <= stop_mode_i & wake_hit;
      if (stop_mode_i && wake_hit) begin
        wake_delay_o <= wake_r[`WAKE_DELAY_BIT];
      end
    end
  end

endmodule

// file: tb/irq_wake_props.sv
// Checker on the interrupt sequencer and wake outputs.
// Sees only the top ports; bound after the module.
`timescale 1ns/1ps
module irq_wake_props (
  input wire clk_i,
  input wire reset_i,
  input wire intr_cycle_o,
  input wire save_ctx_o,
  input wire prog_rd_o,
  input wire [15:0] prog_addr_o,
  input wire [7:0] prog_data_i,
  input wire pc_load_o,
  input wire [15:0] pc_value_o,
  input wire stop_mode_i,
  input wire wake_o,
  input wire wake_delay_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Sequencer order and spacing
  save_first_a: assert property ($rose(intr_cycle_o) |-> save_ctx_o)
    else $error("no context save at cycle start");
  seq_order_a: assert property (save_ctx_o |=> prog_rd_o [*2]
    ##1 !prog_rd_o ##1 pc_load_o) else $error("vector fetch order");
  cycle_len_a: assert property (save_ctx_o |->
    intr_cycle_o [*5] ##1 !intr_cycle_o) else $error("cycle length");
  no_regrant_a: assert property (save_ctx_o |=> !save_ctx_o [*6])
    else $error("second grant inside cycle");
  // Vector bytes and table
  byte_pair_a: assert property ($rose(prog_rd_o) |=> prog_rd_o &&
    prog_addr_o == $past(prog_addr_o) + 16'h0001)
    else $error("second vector byte address");
  vec_table_a: assert property ($rose(prog_rd_o) |->
    prog_addr_o < 16'h000C && !prog_addr_o[0]) else $error("vector slot");
  pc_value_a: assert property (pc_load_o |-> pc_value_o ==
    {$past(prog_data_i, 2), $past(prog_data_i)}) else $error("pc value");
  // Wake outputs
  wake_stop_a: assert property (wake_o |-> $past(stop_mode_i))
    else $error("wake outside stop mode");
  delay_copy_a: assert property ($changed(wake_delay_o) |-> wake_o)
    else $error("delay flag changed without wake");
endmodule

bind vectored_irq_and_stop_wake irq_wake_props i_props (.*);

// file: tb/prog_mem_model.sv
// Program memory holding the vector table.
// Answers the cycle after a read; scrambles its bus otherwise.
`timescale 1ns/1ps
module prog_mem_model (
  input wire clk_i,
  input wire prog_rd_i,
  input wire [15:0] addr_i,
  output reg [7:0] data_o
);
  initial data_o = 8'h00;
  // Vector byte from address, else inverted last value
  always @(posedge clk_i) begin
    if (prog_rd_i) begin
      data_o <= addr_i[7:0] ^ 8'h5A;
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule

// file: tb/tb_vectored_irq_and_stop_wake.sv
// Self-checking bench for the interrupt and stop-wake block.
// Drives the register port, pins and events; memory is a model.
`timescale 1ns/1ps
`include "vectored_irq_defs.vh"
module tb_vectored_irq_and_stop_wake;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg we = 1'b0;
  reg re = 1'b0;
  reg [2:0] pin = 3'h0;
  reg [1:0] cmp = 2'h0;
  reg [3:0] evt = 4'h0;
  reg [7:0] p2 = 8'h00;
  reg [7:0] p2m = 8'h00;
  reg bnd = 1'b0;
  reg stop = 1'b0;
  wire [7:0] rdata;
  wire [7:0] pdata;
  wire [15:0] paddr;
  wire [15:0] pcv;
  wire icyc, save, prd, pload, wake, wdly;
  integer fails = 0;
  integer compares = 0;
  initial forever #2.5 clk_i = ~clk_i;
  vectored_irq_and_stop_wake i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .port3_pin1_i(pin[0]), .port3_pin2_i(pin[1]),
    .port3_pin3_i(pin[2]), .port2_i(p2), .port2_out_mode_i(p2m),
    .comparator_input_a_i(cmp[0]), .comparator_input_b_i(cmp[1]),
    .timer_input_evt_i(evt[0]), .timer16_evt_i(evt[1]),
    .timer8_evt_i(evt[2]), .low_voltage_detector_evt_i(evt[3]),
    .core_boundary_i(bnd), .intr_cycle_o(icyc), .save_ctx_o(save),
    .prog_rd_o(prd), .prog_addr_o(paddr), .prog_data_i(pdata),
    .pc_load_o(pload), .pc_value_o(pcv), .stop_mode_i(stop),
    .wake_o(wake), .wake_delay_o(wdly));
  prog_mem_model i_mem (.clk_i(clk_i), .prog_rd_i(prd), .addr_i(paddr),
    .data_o(pdata));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk_i);
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      addr <= a;
      re <= 1'b1;
      @(posedge clk_i);
      re <= 1'b0;
      #1;
      chk(rdata, exp);
      @(posedge clk_i);
    end
  endtask
  task t_reset;
    begin
      rd(`REQ_REG_ADDR, 8'h00);
      rd(`PRIO_REG_ADDR, 8'h00);
      rd(`MASK_REG_ADDR, 8'h00);
      rd(`WAKE_REG_ADDR, 8'h20);
      rd(8'h55, 8'h00);
    end
  endtask
  task t_edges;
    integer c;
    reg [1:0] s;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        s = c[1:0];
        wr(`REQ_REG_ADDR, {s, 6'h00});
        pin <= 3'b011;
        repeat (3) @(posedge clk_i);
        rd(`REQ_REG_ADDR, {s, 3'h0, s[1], 1'b0, s[0]});
        cmp <= 2'b11;
        repeat (3) @(posedge clk_i);
        wr(`REQ_REG_ADDR, {s, 6'h00});
        cmp <= 2'b00;
        repeat (3) @(posedge clk_i);
        rd(`REQ_REG_ADDR, {s, 3'h0, s != 2'b10, 1'b0, s != 2'b01});
        pin <= 3'b000;
        repeat (3) @(posedge clk_i);
      end
      wr(`REQ_REG_ADDR, 8'h00);
    end
  endtask
  task grant(input [7:0] s);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge clk_i);
        #1;
        n = n + 1;
      end while (pload !== 1'b1 && n < 20);
      chk(pload, 1'b1);
      chk(pcv, {{s[6:0], 1'b0} ^ 8'h5A, {s[6:0], 1'b1} ^ 8'h5A});
      @(posedge clk_i);
    end
  endtask
  // Request one, timer input and timer8 sources; no grant off boundary
  task t_srcs;
    begin
      pin <= 3'b100;
      @(posedge clk_i);
      pin <= 3'b000;
      evt <= 4'b0101;
      @(posedge clk_i);
      evt <= 4'h0;
      repeat (2) @(posedge clk_i);
      rd(`REQ_REG_ADDR, 8'h16);
      wr(`MASK_REG_ADDR, 8'h96);
      repeat (3) @(posedge clk_i);
      rd(`REQ_REG_ADDR, 8'h16);
      wr(`MASK_REG_ADDR, 8'h00);
      wr(`REQ_REG_ADDR, 8'h00);
    end
  endtask
  task t_vec;
    begin
      wr(`PRIO_REG_ADDR, 8'h04);
      evt <= 4'b1010;
      @(posedge clk_i);
      evt <= 4'h0;
      repeat (2) @(posedge clk_i);
      rd(`REQ_REG_ADDR, 8'h28);
      bnd <= 1'b1;
      wr(`MASK_REG_ADDR, 8'hA8);
      grant(8'h05);
      rd(`MASK_REG_ADDR, 8'h28);
      rd(`REQ_REG_ADDR, 8'h08);
      wr(`MASK_REG_ADDR, 8'hA8);
      grant(8'h03);
      bnd <= 1'b0;
    end
  endtask
  task t_wake;
    integer c;
    begin
      stop <= 1'b1;
      for (c = 0; c < 8; c = c + 1) begin
        wr(`WAKE_REG_ADDR, {3'b011, c[2:0], 2'b00});
        pin <= 3'b000;
        p2 <= 8'h00;
        repeat (6) @(posedge clk_i);
        #1 chk(wake, c > 5);
        @(posedge clk_i);
        pin <= 3'b111;
        p2 <= 8'hFF;
        repeat (6) @(posedge clk_i);
        #1 chk(wake, c > 1 && c < 6);
        @(posedge clk_i);
      end
      wr(`WAKE_REG_ADDR, 8'h78);
      p2 <= 8'h01;
      p2m <= 8'h01;
      repeat (6) @(posedge clk_i);
      #1 chk(wake, 1'b1);
      @(posedge clk_i);
      p2m <= 8'h00;
      repeat (6) @(posedge clk_i);
      #1 chk(wake, 1'b0);
      @(posedge clk_i);
      wr(`WAKE_REG_ADDR, 8'h08);
      pin <= 3'b000;
      repeat (6) @(posedge clk_i);
      #1 chk(wake, 1'b1);
      chk(wdly, 1'b0);
      @(posedge clk_i);
      rd(`WAKE_REG_ADDR, 8'h88);
      stop <= 1'b0;
    end
  endtask
  task summarize;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // Watchdog against a hung handshake
  initial begin
    #50000;
    fails = fails + 1;
    summarize;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_edges;
    t_srcs;
    t_vec;
    t_wake;
    summarize;
  end
endmodule
